// ===== pmt_div_if.sv
// Purpose: Links the timer core to one of its divide-by-N counters
// Assumes: Single clock domain
// Notes:   wrap is combinational from the counter state
`timescale 1ns/1ps
interface pmt_div_if;
    logic       step;                                   // Count one input event
    logic       clear;                                  // Synchronous counter clear
    logic [3:0] limit;                                  // Terminal count, ratio minus one
    logic       wrap;                                   // Output event of the divider

    modport ctl (output step, output clear, output limit, input wrap);
    modport div (input step, input clear, input limit, output wrap);
endinterface

// ===== pmt_divider.sv
// Purpose: Divide-by-(limit+1) event counter used as prescaler and postscaler
// Assumes: Synchronous active-low reset
// Notes:   Clear beats step, so a clearing write never lets an event slip through
`timescale 1ns/1ps
module pmt_divider (
    input  wire logic aclk,
    input  wire logic aresetn,
    pmt_div_if.div    dif
);

    typedef struct packed {
        logic [3:0] count;                              // Events seen since last wrap
    } pmt_div_s;

    pmt_div_s st_reg;
    pmt_div_s st_next;

    // Wrap on the event that reaches the terminal count
    assign dif.wrap = dif.step && !dif.clear && (st_reg.count == dif.limit);

    // Next-state logic
    always_comb begin
        st_next = st_reg;
        if (dif.clear) begin
            st_next.count = 4'h0;
        end else if (dif.wrap) begin
            st_next.count = 4'h0;
        end else if (dif.step) begin
            st_next.count = st_reg.count + 4'h1;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// ===== pmt_pkg.sv
// Purpose: Shared constants and types for the 8-bit period match timer
// Assumes: aclk is the instruction clock, so one aclk cycle is one instruction cycle
// Notes:   Registers are 8 bits wide and sit in the low byte of one aligned 32-bit word
package pmt_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 8;                 // AXI address width
    localparam logic [7:0]  WORD_MASK = 8'hFC;          // Word alignment mask

    // Register byte offsets
    localparam logic [7:0]  OFS_CONTROL    = 8'h00;     // timer_control
    localparam logic [7:0]  OFS_COUNT      = 8'h04;     // tick_count
    localparam logic [7:0]  OFS_PERIOD     = 8'h08;     // period_limit
    localparam logic [7:0]  OFS_FLAGS      = 8'h0C;     // peripheral_int_flags
    localparam logic [7:0]  OFS_ENABLES    = 8'h10;     // peripheral_int_enables
    localparam logic [7:0]  OFS_FLAG_CLEAR = 8'h14;     // Write-one-to-clear for flags

    // timer_control field layout
    localparam int unsigned CTL_PRE_LSB  = 0;           // pre_divide_select, 2 bits
    localparam int unsigned CTL_RUN_BIT  = 2;           // run_enable_bit
    localparam int unsigned CTL_POST_LSB = 3;           // post_divide_select, 4 bits
    localparam logic [7:0]  CTL_MASK     = 8'h7F;       // Top bit unimplemented

    // Flag and enable bit position of the match event
    localparam int unsigned MATCH_BIT = 1;
    localparam logic [7:0]  MATCH_MASK = 8'h02;

    // Reset values
    localparam logic [7:0]  RST_CONTROL = 8'h00;
    localparam logic [7:0]  RST_COUNT   = 8'h00;
    localparam logic [7:0]  RST_PERIOD  = 8'hFF;
    localparam logic [7:0]  RST_FLAGS   = 8'h00;
    localparam logic [7:0]  RST_ENABLES = 8'h00;

    // Prescaler terminal counts (ratio minus one)
    localparam logic [3:0]  PRE_LIMIT_1  = 4'h0;
    localparam logic [3:0]  PRE_LIMIT_4  = 4'h3;
    localparam logic [3:0]  PRE_LIMIT_16 = 4'hF;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Write channel phase
    typedef enum logic [1:0] {
        WP_COLLECT = 2'h1,                              // Gathering address and data
        WP_RESP    = 2'h2                               // Response offered
    } pmt_wphase_e;

    // Read channel phase
    typedef enum logic [1:0] {
        RP_ADDR = 2'h1,                                 // Waiting for an address
        RP_DATA = 2'h2                                  // Read data offered
    } pmt_rphase_e;

endpackage

// ===== pmt_props.sv
// Purpose: Port-level checks for the period match timer
// Assumes: One clock domain; aresetn synchronous, active low
// Notes:   Bound to the timer from the testbench top file
`timescale 1ns/1ps
module pmt_props (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic [pmt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic [31:0]                s_axi_wdata,
    input wire logic [3:0]                 s_axi_wstrb,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic [1:0]                 s_axi_bresp,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_bready,
    input wire logic [pmt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic [31:0]                s_axi_rdata,
    input wire logic [1:0]                 s_axi_rresp,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    input wire logic                       irq
);
    logic [7:0] rd_addr_reg;    // Word address of the read in flight

    // Remember which word a read asked for, to judge its data
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_reg <= s_axi_araddr & pmt_pkg::WORD_MASK;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Reset must silence responses and the interrupt, so no disable here
    a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy after reset");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_ready_back: assert property (
        s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write readies not restored");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_ctl_top_zero: assert property (
        s_axi_rvalid && rd_addr_reg == pmt_pkg::OFS_CONTROL |-> !s_axi_rdata[7])
        else $error("control top bit reads one");
    // The flag only goes away through a software write, so irq falls near a response
    a_irq_sticky: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt fell without a write");

    c_irq_rise: cover property ($rose(irq));
    c_read_err: cover property (s_axi_rvalid && s_axi_rresp == pmt_pkg::RESP_SLVERR);
    c_write_ok: cover property (s_axi_bvalid && s_axi_bresp == pmt_pkg::RESP_OKAY);
endmodule

// ===== pmt_timer8.sv
// Purpose: 8-bit period match timer with prescaler, postscaler and AXI4-Lite registers
// Assumes: aclk at 100 MHz is the instruction clock; aresetn is synchronous, active low
// Notes:   One write and one read may be in flight together; each answers one cycle
//          after its last handshake
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps

// How it works
// - Instruction clock through prescaler drives count
// - Count runs to period, then wraps zero
// - Every match advances the postscaler once
// - Postscaler wrap sets the match event flag
// - Count and period readable and writable always
// - Reset gives count zero, period all ones
// - Counting only while run enable bit set
// - Count or control write clears both scalers
// - Control write leaves the count untouched
// - Postscale ratio is field value plus one
// - Prescale 00 by 1, 01 by 4, 1x by 16
// - Control layout post, run, pre; top bit zero
module pmt_timer8 (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [pmt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [pmt_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            irq
);

    // All state of the block except the two divider counters
    typedef struct packed {
        pmt_pkg::pmt_wphase_e       wphase;            // Write channel phase
        logic                       aw_got;            // Write address held
        logic                       w_got;             // Write data held
        logic [pmt_pkg::ADDR_W-1:0] waddr;             // Held write address
        logic [7:0]                 wdata;             // Held low data byte
        logic                       wlane;             // Held strobe of the low byte
        logic                       awready;           // Address channel ready
        logic                       wready;            // Data channel ready
        logic                       bvalid;            // Write response valid
        logic [1:0]                 bresp;             // Write response code
        pmt_pkg::pmt_rphase_e       rphase;            // Read channel phase
        logic                       arready;           // Read address ready
        logic                       rvalid;            // Read data valid
        logic [7:0]                 rdata;             // Read data low byte
        logic [1:0]                 rresp;             // Read response code
        logic [7:0]                 control;           // timer_control
        logic [7:0]                 count;             // tick_count
        logic [7:0]                 period;            // period_limit
        logic [7:0]                 flags;             // peripheral_int_flags
        logic [7:0]                 enables;           // peripheral_int_enables
        logic                       irq;               // Registered interrupt line
    } pmt_top_s;

    pmt_top_s st_reg;
    pmt_top_s st_next;

    // Divider links
    pmt_div_if pre_if ();                               // Prescaler
    pmt_div_if post_if ();                              // Postscaler

    // Write path helpers
    logic                       aw_fire;                // Address taken this edge
    logic                       w_fire;                 // Data taken this edge
    logic                       do_wr;                  // Register write this cycle
    logic [pmt_pkg::ADDR_W-1:0] wa;                     // Effective write address
    logic [7:0]                 wd;                     // Effective write byte
    logic                       wl;                     // Effective low-byte strobe
    logic [7:0]                 wword;                  // Aligned write address
    logic                       wr_hit;                 // Write address is mapped
    logic                       wr_ctl;                 // Write to timer_control
    logic                       wr_cnt;                 // Write to tick_count

    // Read path helpers
    logic                       ar_fire;                // Read address taken
    logic [7:0]                 rword;                  // Aligned read address
    logic [7:0]                 rd_byte;                // Selected register value
    logic                       rd_hit;                 // Read address is mapped

    // Timer helpers
    logic                       tick;                   // Prescaler output event
    logic                       match;                  // Count equals period
    logic [1:0]                 pre_sel;                // pre_divide_select
    logic [3:0]                 post_sel;               // post_divide_select

    // Channel handshakes
    assign aw_fire = s_axi_awvalid && st_reg.awready;
    assign w_fire  = s_axi_wvalid && st_reg.wready;
    assign ar_fire = s_axi_arvalid && st_reg.arready;

    // Held values win over the bus once a channel was taken earlier
    assign wa = st_reg.aw_got ? st_reg.waddr : s_axi_awaddr;
    assign wd = st_reg.w_got ? st_reg.wdata : s_axi_wdata[7:0];
    assign wl = st_reg.w_got ? st_reg.wlane : s_axi_wstrb[0];

    // The write happens in the cycle both halves are present
    assign do_wr = (st_reg.wphase == pmt_pkg::WP_COLLECT)
                   && (st_reg.aw_got || aw_fire)
                   && (st_reg.w_got || w_fire);

    // Address decode for writes; a missing low strobe leaves the register as is
    assign wword  = wa & pmt_pkg::WORD_MASK;
    assign wr_hit = (wword <= pmt_pkg::OFS_FLAG_CLEAR);
    assign wr_ctl = do_wr && wl && (wword == pmt_pkg::OFS_CONTROL);
    assign wr_cnt = do_wr && wl && (wword == pmt_pkg::OFS_COUNT);

    // Control fields
    assign pre_sel  = st_reg.control[pmt_pkg::CTL_PRE_LSB +: 2];
    assign post_sel = st_reg.control[pmt_pkg::CTL_POST_LSB +: 4];

    // Prescaler runs on every instruction clock while enabled
    assign pre_if.step  = st_reg.control[pmt_pkg::CTL_RUN_BIT];
    assign pre_if.clear = wr_ctl || wr_cnt;
    // Upper select bit alone picks 16, so both 1x codes agree
    assign pre_if.limit = pre_sel[1] ? pmt_pkg::PRE_LIMIT_16
                        : (pre_sel[0] ? pmt_pkg::PRE_LIMIT_4 : pmt_pkg::PRE_LIMIT_1);
    assign tick = pre_if.wrap;

    // Comparator watches count and period at all times
    assign match = (st_reg.count == st_reg.period);

    // Postscaler counts matches, ratio is the field plus one
    assign post_if.step  = tick && match;
    assign post_if.clear = wr_ctl || wr_cnt;
    assign post_if.limit = post_sel;

    pmt_divider u_prescale (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dif     (pre_if)
    );

    pmt_divider u_postscale (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dif     (post_if)
    );

    // Read decode; unmapped words read zero with an error response
    assign rword = s_axi_araddr & pmt_pkg::WORD_MASK;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        unique case (rword)
            pmt_pkg::OFS_CONTROL: begin
                rd_byte = st_reg.control & pmt_pkg::CTL_MASK;
            end
            pmt_pkg::OFS_COUNT: begin
                rd_byte = st_reg.count;
            end
            pmt_pkg::OFS_PERIOD: begin
                rd_byte = st_reg.period;
            end
            pmt_pkg::OFS_FLAGS: begin
                rd_byte = st_reg.flags;
            end
            pmt_pkg::OFS_ENABLES: begin
                rd_byte = st_reg.enables;
            end
            pmt_pkg::OFS_FLAG_CLEAR: begin
                rd_byte = 8'h00;                                // Write-only
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Next-state logic: bus channels, registers, timer
    always_comb begin
        st_next = st_reg;

        // Write channel
        unique case (st_reg.wphase)
            pmt_pkg::WP_COLLECT: begin
                if (do_wr) begin
                    st_next.wphase  = pmt_pkg::WP_RESP;
                    st_next.aw_got  = 1'b0;
                    st_next.w_got   = 1'b0;
                    st_next.awready = 1'b0;
                    st_next.wready  = 1'b0;
                    st_next.bvalid  = 1'b1;
                    st_next.bresp   = wr_hit ? pmt_pkg::RESP_OKAY : pmt_pkg::RESP_SLVERR;
                end else begin
                    // One half arrived alone: hold it and close that channel
                    if (aw_fire) begin
                        st_next.aw_got  = 1'b1;
                        st_next.waddr   = s_axi_awaddr;
                        st_next.awready = 1'b0;
                    end
                    if (w_fire) begin
                        st_next.w_got  = 1'b1;
                        st_next.wdata  = s_axi_wdata[7:0];
                        st_next.wlane  = s_axi_wstrb[0];
                        st_next.wready = 1'b0;
                    end
                end
            end
            pmt_pkg::WP_RESP: begin
                if (s_axi_bready) begin
                    st_next.wphase  = pmt_pkg::WP_COLLECT;
                    st_next.bvalid  = 1'b0;
                    st_next.awready = 1'b1;
                    st_next.wready  = 1'b1;
                end
            end
            default: begin
                st_next.wphase = pmt_pkg::WP_COLLECT;
            end
        endcase

        // Read channel; data is sampled at the address handshake
        unique case (st_reg.rphase)
            pmt_pkg::RP_ADDR: begin
                if (ar_fire) begin
                    st_next.rphase  = pmt_pkg::RP_DATA;
                    st_next.arready = 1'b0;
                    st_next.rvalid  = 1'b1;
                    st_next.rdata   = rd_byte;
                    st_next.rresp   = rd_hit ? pmt_pkg::RESP_OKAY : pmt_pkg::RESP_SLVERR;
                end
            end
            pmt_pkg::RP_DATA: begin
                if (s_axi_rready) begin
                    st_next.rphase  = pmt_pkg::RP_ADDR;
                    st_next.rvalid  = 1'b0;
                    st_next.arready = 1'b1;
                end
            end
            default: begin
                st_next.rphase = pmt_pkg::RP_ADDR;
            end
        endcase

        // Count advances on a prescaler tick, wrapping after the match
        if (tick) begin
            st_next.count = match ? 8'h00 : st_reg.count + 8'h01;
        end

        // Software writes override the timer's count update in the same cycle
        if (do_wr && wl) begin
            unique case (wword)
                pmt_pkg::OFS_CONTROL: begin
                    // Scalers clear but the count stays put
                    st_next.control = wd & pmt_pkg::CTL_MASK;
                    st_next.count   = st_reg.count;
                end
                pmt_pkg::OFS_COUNT: begin
                    st_next.count = wd;
                end
                pmt_pkg::OFS_PERIOD: begin
                    st_next.period = wd;
                end
                pmt_pkg::OFS_FLAGS: begin
                    // Writing zero clears the flag, writing one raises it
                    st_next.flags = wd & pmt_pkg::MATCH_MASK;
                end
                pmt_pkg::OFS_ENABLES: begin
                    st_next.enables = wd & pmt_pkg::MATCH_MASK;
                end
                pmt_pkg::OFS_FLAG_CLEAR: begin
                    st_next.flags = st_reg.flags & ~(wd & pmt_pkg::MATCH_MASK);
                end
                default: begin
                    st_next.flags = st_next.flags;              // Unmapped: no effect
                end
            endcase
        end

        // Hardware set wins over any clear in the same cycle
        if (post_if.wrap) begin
            st_next.flags[pmt_pkg::MATCH_BIT] = 1'b1;
        end

        // Level interrupt while an enabled flag stands
        st_next.irq = |(st_next.flags & st_next.enables);
    end

    // State register; reset loads the documented values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg         <= '0;
            st_reg.wphase  <= pmt_pkg::WP_COLLECT;
            st_reg.rphase  <= pmt_pkg::RP_ADDR;
            st_reg.awready <= 1'b1;
            st_reg.wready  <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.control <= pmt_pkg::RST_CONTROL;
            st_reg.count   <= pmt_pkg::RST_COUNT;
            st_reg.period  <= pmt_pkg::RST_PERIOD;
            st_reg.flags   <= pmt_pkg::RST_FLAGS;
            st_reg.enables <= pmt_pkg::RST_ENABLES;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = {24'h000000, st_reg.rdata};
    assign s_axi_rresp   = st_reg.rresp;
    assign irq           = st_reg.irq;

endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the period match timer
// Assumes: 100 MHz aclk; reset held 12 cycles; responses checked in order
// Notes:   Timer stays stopped whenever a count is read back
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        irq;
    int          fail_count = 0;
    int          samples_checked = 0;
    logic [33:0] exp_q[$];        // Expected {resp, data} per response, oldest first
    logic [33:0] got_v, exp_v;
    logic [7:0]  rst_tab [5] = '{pmt_pkg::RST_CONTROL, pmt_pkg::RST_COUNT,
        pmt_pkg::RST_PERIOD, pmt_pkg::RST_FLAGS, pmt_pkg::RST_ENABLES};

    pmt_timer8 dut_u (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Longest run is under 7k cycles, so 100k means a hang
    initial begin
        #1000000;
        fail_count++;
        close_out();
    end

    // Each response taken is matched against the oldest note
    always @(posedge aclk) begin
        if (aresetn && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
            got_v = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h00000000};
            exp_v = exp_q.pop_front();
            `CHK(got_v, exp_v)
        end
    end

    // Offer address and data together; drop each once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = pmt_pkg::RESP_OKAY);
        bit ad = 0;
        bit wd = 0;
        exp_q.push_back({r, 32'h00000000});
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wd) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = pmt_pkg::RESP_OKAY);
        exp_q.push_back({r, 24'h000000, d});
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Registers sit at word offsets 00..10 in table order
    task automatic chk_rst();
        for (int i = 0; i < 5; i++) begin
            rd(8'(4 * i), rst_tab[i]);
        end
    endtask

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        int         n;
        int         dv;
        logic [1:0] pre;
        logic [3:0] post;
        logic [7:0] per;
        logic [7:0] v;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        void'($urandom(34));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        chk_rst();
        rd(pmt_pkg::OFS_FLAG_CLEAR, 8'h00);
        // Unmapped word answers with an error
        wr(8'h18, 8'hFF, pmt_pkg::RESP_SLVERR);
        rd(8'h18, 8'h00, pmt_pkg::RESP_SLVERR);
        // Random register traffic with the timer stopped
        repeat (4) begin
            per = 8'($urandom);
            wr(pmt_pkg::OFS_PERIOD, per);
            rd(pmt_pkg::OFS_PERIOD, per);
            v = (8'($urandom) & 8'hFB) | 8'h80;
            per = 8'($urandom);
            wr(pmt_pkg::OFS_COUNT, per);
            wr(pmt_pkg::OFS_CONTROL, v);
            repeat (20) @(posedge aclk);
            rd(pmt_pkg::OFS_COUNT, per);
            rd(pmt_pkg::OFS_CONTROL, v & 8'h7F);
        end
        // Flag latency for every prescale code, postscale ends and random mids
        wr(pmt_pkg::OFS_ENABLES, pmt_pkg::MATCH_MASK);
        for (int i = 0; i < 8; i++) begin
            pre = 2'(i);
            post = (i < 4) ? 4'(15 * (i % 2)) : 4'($urandom_range(15));
            per = 8'($urandom_range(5));
            dv = (pre == 2'b00) ? 1 : (pre == 2'b01) ? 4 : 16;
            wr(pmt_pkg::OFS_CONTROL, 8'h00);
            wr(pmt_pkg::OFS_PERIOD, per);
            wr(pmt_pkg::OFS_COUNT, 8'h00);
            wr(pmt_pkg::OFS_FLAGS, 8'h00);
            wr(pmt_pkg::OFS_CONTROL, {1'b0, post, 1'b1, pre});
            n = 1;
            while (irq !== 1'b1 && n < 5000) begin
                @(posedge aclk);
                n++;
            end
            `CHK(n, 1 + dv * (per + 1) * (post + 1))
            rd(pmt_pkg::OFS_FLAGS, pmt_pkg::MATCH_MASK);
        end
        // Flag held while stopped: mask, unmask, then clear
        wr(pmt_pkg::OFS_CONTROL, 8'h00);
        wr(pmt_pkg::OFS_ENABLES, 8'h00);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        wr(pmt_pkg::OFS_ENABLES, pmt_pkg::MATCH_MASK);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1)
        wr(pmt_pkg::OFS_FLAG_CLEAR, pmt_pkg::MATCH_MASK);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        rd(pmt_pkg::OFS_FLAGS, 8'h00);
        // Reset in mid-run restores every register
        wr(pmt_pkg::OFS_CONTROL, 8'h7C);
        repeat (30) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        chk_rst();
        close_out();
    end
endmodule

bind pmt_timer8 pmt_props chk_u (.*);
